/* dee_pkg.sv */
// constants shared by the data eeprom access controller
package dee_pkg;
   // function register addresses
   localparam logic [7:0] SFR_DP0_LO = 8'h82;
   localparam logic [7:0] SFR_DP0_HI = 8'h83;
   localparam logic [7:0] SFR_DP1_LO = 8'h84;
   localparam logic [7:0] SFR_DP1_HI = 8'h85;
   localparam logic [7:0] SFR_MEMCTL = 8'h96;
   // memory_control bit positions
   localparam int MC_PAGE_LOAD = 5;
   localparam int MC_WR_EN = 4;
   localparam int MC_EE_SEL = 3;
   localparam int MC_PTR_SEL = 2;
   localparam int MC_READY = 1;
   localparam int MC_WINH = 0;
   // reset values
   localparam logic [15:0] DP_RST = 16'h0000;
   localparam logic MC_BIT_RST = 1'h0;
   // eeprom geometry
   localparam logic [15:0] EE_LAST_ADDR = 16'h07ff;
   localparam int EE_AW = 11;
   localparam int PAGE_BYTES = 32;
   localparam int PAGE_IW = 5;
   localparam int PAGE_NW = EE_AW - PAGE_IW;
   localparam logic [7:0] MSB_FLIP = 8'h80;
   // timing
   localparam int PROG_TIME_MS = 4;
   localparam int CLK_HZ = 25000000;
   localparam int PROG_CYCLES = PROG_TIME_MS * (CLK_HZ / 1000);
   localparam int CNT_W = 17;
   localparam int START_DELAY = 4;
endpackage : dee_pkg

/* dee_ctrl.sv */
// data eeprom access controller: pointer banks, move routing, page programming
//
// Overview of operation
// - select set routes moves to eeprom
// - eeprom decodes addresses 000H through 7FFH
// - select clear routes moves off-chip
// - byte write changes only the addressed byte
// - no write without write enable set
// - programming self-timed, about 4 ms
// - ready reads 0 busy, 1 done
// - page-load set only fills write buffer
// - load clear programs whole buffered page
// - page programming takes one 4 ms interval
// - busy read returns written byte, MSB inverted
// - two pointer banks at 82H and 84H
// - pointer select picks bank zero or one
// - memory_control at 96H, bits 5..0
// - addresses 2K and above go off-chip
// - ready clears after the move completes
`timescale 1ns/100ps
`default_nettype none
module dee_ctrl #(
   parameter int unsigned PROG_CYCLES = dee_pkg::PROG_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // function register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // external data move from the core
   input wire logic mv_req,
   input wire logic mv_write,
   input wire logic [7:0] mv_wdata,
   output logic [7:0] mv_rdata,
   output logic mv_done,
   // off-chip data memory
   output logic ext_req,
   output logic ext_write,
   output logic [15:0] ext_addr,
   output logic [7:0] ext_wdata,
   input wire logic ext_ack,
   input wire logic [7:0] ext_rdata,
   // eeprom array
   output logic ee_rd,
   output logic ee_wr,
   output logic [10:0] ee_addr,
   output logic [7:0] ee_wdata,
   input wire logic [7:0] ee_rdata,
   // supply monitor pin, high when programming is allowed
   input wire logic supply_ok_in
);
   // move sequencer states
   typedef enum logic [2:0] {
      MV_IDLE = 3'b001,
      MV_EE_RD = 3'b010,
      MV_EXT = 3'b100
   } dee_mv_t;
   // programming sequencer states
   typedef enum logic [3:0] {
      PG_IDLE = 4'b0001,
      PG_DELAY = 4'b0010,
      PG_TIMER = 4'b0100,
      PG_COMMIT = 4'b1000
   } dee_pg_t;

   // eeprom decode shared by both move directions
   function automatic logic is_ee(input logic [15:0] a, input logic sel);
      is_ee = sel && (a <= dee_pkg::EE_LAST_ADDR);
   endfunction : is_ee

   // register state, move group
   dee_mv_t mv_st_reg, mv_st_next;
   logic [15:0] dp0_reg, dp0_next; // pointer bank zero
   logic [15:0] dp1_reg, dp1_next; // pointer bank one
   logic page_load_reg, page_load_next;
   logic wr_en_reg, wr_en_next;
   logic ee_sel_reg, ee_sel_next;
   logic ptr_sel_reg, ptr_sel_next;
   logic [7:0] sfr_rdata_reg, sfr_rdata_next;
   logic [7:0] mv_rdata_reg, mv_rdata_next;
   logic mv_done_reg, mv_done_next;
   logic ext_req_reg, ext_req_next;
   logic ext_write_reg, ext_write_next;
   logic [15:0] ext_addr_reg, ext_addr_next;
   logic [7:0] ext_wdata_reg, ext_wdata_next;
   // requests handed from the move group to the programming group
   logic wr_ee_go;
   logic rd_ee_go;
   logic [15:0] act_ptr; // active_pointer_pair

   // programming group
   dee_pg_t pg_st_reg, pg_st_next;
   logic [dee_pkg::CNT_W-1:0] cnt_reg, cnt_next;
   logic [7:0] buf_reg [dee_pkg::PAGE_BYTES], buf_next [dee_pkg::PAGE_BYTES];
   logic [dee_pkg::PAGE_BYTES-1:0] mask_reg, mask_next; // bytes loaded
   logic [dee_pkg::PAGE_NW-1:0] page_reg, page_next;
   logic [dee_pkg::PAGE_IW-1:0] idx_reg, idx_next; // commit walk index
   logic [7:0] last_reg, last_next; // byte being written
   logic ee_rd_reg, ee_rd_next;
   logic ee_wr_reg, ee_wr_next;
   logic [10:0] ee_addr_reg, ee_addr_next;
   logic [7:0] ee_wdata_reg, ee_wdata_next;

   // supply pin synchroniser; the first stage feeds only the second
   logic sync1_reg, sync2_reg, sync3_reg;
   logic winh_ok_reg, winh_ok_next; // write_inhibit_flag, 1 = allowed

   // status seen by software and by the write path
   logic ready_flag; // eeprom_ready_flag
   logic wr_allowed;

   // ready stays high through the start delay so it falls after the move
   assign ready_flag = (pg_st_reg == PG_IDLE) || (pg_st_reg == PG_DELAY);
   assign wr_allowed = wr_en_reg && winh_ok_reg && (pg_st_reg == PG_IDLE);
   assign act_ptr = ptr_sel_reg ? dp1_reg : dp0_reg;

   // flag accepts a new level only when stages two and three agree
   always_comb begin
      winh_ok_next = winh_ok_reg;
      if (sync2_reg == sync3_reg) begin
         winh_ok_next = sync3_reg;
      end
   end

   // supply synchroniser registers
   always_ff @(posedge clk) begin
      if (srst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         sync3_reg <= 1'b0;
         winh_ok_reg <= 1'b0;
      end else begin
         sync1_reg <= supply_ok_in;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         winh_ok_reg <= winh_ok_next;
      end
   end

   // register port and move sequencer, next values
   always_comb begin
      mv_st_next = mv_st_reg;
      dp0_next = dp0_reg;
      dp1_next = dp1_reg;
      page_load_next = page_load_reg;
      wr_en_next = wr_en_reg;
      ee_sel_next = ee_sel_reg;
      ptr_sel_next = ptr_sel_reg;
      sfr_rdata_next = sfr_rdata_reg;
      mv_rdata_next = mv_rdata_reg;
      mv_done_next = 1'b0;
      ext_req_next = ext_req_reg;
      ext_write_next = ext_write_reg;
      ext_addr_next = ext_addr_reg;
      ext_wdata_next = ext_wdata_reg;
      wr_ee_go = 1'b0;
      rd_ee_go = 1'b0;
      // software writes to the function registers
      if (sfr_wr) begin
         unique case (sfr_addr)
            dee_pkg::SFR_DP0_LO: dp0_next[7:0] = sfr_wdata;
            dee_pkg::SFR_DP0_HI: dp0_next[15:8] = sfr_wdata;
            dee_pkg::SFR_DP1_LO: dp1_next[7:0] = sfr_wdata;
            dee_pkg::SFR_DP1_HI: dp1_next[15:8] = sfr_wdata;
            dee_pkg::SFR_MEMCTL: begin
               page_load_next = sfr_wdata[dee_pkg::MC_PAGE_LOAD];
               wr_en_next = sfr_wdata[dee_pkg::MC_WR_EN];
               ee_sel_next = sfr_wdata[dee_pkg::MC_EE_SEL];
               ptr_sel_next = sfr_wdata[dee_pkg::MC_PTR_SEL];
            end
            default: ; // other addresses belong elsewhere
         endcase
      end
      // reads answer the next cycle; unmapped addresses give zero
      if (sfr_rd) begin
         unique case (sfr_addr)
            dee_pkg::SFR_DP0_LO: sfr_rdata_next = dp0_reg[7:0];
            dee_pkg::SFR_DP0_HI: sfr_rdata_next = dp0_reg[15:8];
            dee_pkg::SFR_DP1_LO: sfr_rdata_next = dp1_reg[7:0];
            dee_pkg::SFR_DP1_HI: sfr_rdata_next = dp1_reg[15:8];
            dee_pkg::SFR_MEMCTL: begin
               sfr_rdata_next = 8'h00;
               sfr_rdata_next[dee_pkg::MC_PAGE_LOAD] = page_load_reg;
               sfr_rdata_next[dee_pkg::MC_WR_EN] = wr_en_reg;
               sfr_rdata_next[dee_pkg::MC_EE_SEL] = ee_sel_reg;
               sfr_rdata_next[dee_pkg::MC_PTR_SEL] = ptr_sel_reg;
               sfr_rdata_next[dee_pkg::MC_READY] = ready_flag;
               sfr_rdata_next[dee_pkg::MC_WINH] = winh_ok_reg;
            end
            default: sfr_rdata_next = 8'h00;
         endcase
      end
      unique case (mv_st_reg)
         MV_IDLE: begin
            if (mv_req) begin
               if (is_ee(act_ptr, ee_sel_reg)) begin
                  if (mv_write) begin
                     // refused writes still complete, the array is untouched
                     wr_ee_go = 1'b1;
                     mv_done_next = 1'b1;
                  end else if (!ready_flag) begin
                     mv_rdata_next = last_reg ^ dee_pkg::MSB_FLIP;
                     mv_done_next = 1'b1;
                  end else begin
                     rd_ee_go = 1'b1;
                     mv_st_next = MV_EE_RD;
                  end
               end else begin
                  ext_req_next = 1'b1;
                  ext_write_next = mv_write;
                  ext_addr_next = act_ptr;
                  ext_wdata_next = mv_wdata;
                  mv_st_next = MV_EXT;
               end
            end
         end
         MV_EE_RD: begin
            mv_rdata_next = ee_rdata;
            mv_done_next = 1'b1;
            mv_st_next = MV_IDLE;
         end
         MV_EXT: begin
            // off-chip request is held as a level until acknowledged
            if (ext_ack) begin
               ext_req_next = 1'b0;
               if (!ext_write_reg) begin
                  mv_rdata_next = ext_rdata;
               end
               mv_done_next = 1'b1;
               mv_st_next = MV_IDLE;
            end
         end
      endcase
   end

   // register port and move sequencer registers
   always_ff @(posedge clk) begin
      if (srst) begin
         mv_st_reg <= MV_IDLE;
         dp0_reg <= dee_pkg::DP_RST;
         dp1_reg <= dee_pkg::DP_RST;
         page_load_reg <= dee_pkg::MC_BIT_RST;
         wr_en_reg <= dee_pkg::MC_BIT_RST;
         ee_sel_reg <= dee_pkg::MC_BIT_RST;
         ptr_sel_reg <= dee_pkg::MC_BIT_RST;
         sfr_rdata_reg <= 8'h00;
         mv_rdata_reg <= 8'h00;
         mv_done_reg <= 1'b0;
         ext_req_reg <= 1'b0;
         ext_write_reg <= 1'b0;
         ext_addr_reg <= 16'h0000;
         ext_wdata_reg <= 8'h00;
      end else begin
         mv_st_reg <= mv_st_next;
         dp0_reg <= dp0_next;
         dp1_reg <= dp1_next;
         page_load_reg <= page_load_next;
         wr_en_reg <= wr_en_next;
         ee_sel_reg <= ee_sel_next;
         ptr_sel_reg <= ptr_sel_next;
         sfr_rdata_reg <= sfr_rdata_next;
         mv_rdata_reg <= mv_rdata_next;
         mv_done_reg <= mv_done_next;
         ext_req_reg <= ext_req_next;
         ext_write_reg <= ext_write_next;
         ext_addr_reg <= ext_addr_next;
         ext_wdata_reg <= ext_wdata_next;
      end
   end

   // write buffer and programming sequencer, next values
   always_comb begin
      pg_st_next = pg_st_reg;
      cnt_next = cnt_reg;
      buf_next = buf_reg;
      mask_next = mask_reg;
      page_next = page_reg;
      idx_next = idx_reg;
      last_next = last_reg;
      ee_rd_next = 1'b0;
      ee_wr_next = 1'b0;
      ee_addr_next = ee_addr_reg;
      ee_wdata_next = ee_wdata_reg;
      // array read for an idle eeprom; data is taken while ee_rd is high
      if (rd_ee_go) begin
         ee_rd_next = 1'b1;
         ee_addr_next = act_ptr[10:0];
      end
      unique case (pg_st_reg)
         PG_IDLE: begin
            if (wr_ee_go && wr_allowed) begin
               // a load to another page drops the stale buffer
               if (act_ptr[10:5] != page_reg) begin
                  mask_next = '0;
               end
               buf_next[act_ptr[4:0]] = mv_wdata;
               mask_next[act_ptr[4:0]] = 1'b1;
               page_next = act_ptr[10:5];
               last_next = mv_wdata;
               if (!page_load_reg) begin
                  cnt_next = dee_pkg::CNT_W'(dee_pkg::START_DELAY - 1);
                  pg_st_next = PG_DELAY;
               end
            end
         end
         PG_DELAY: begin
            if (cnt_reg == '0) begin
               // one timed interval for the whole page
               cnt_next = dee_pkg::CNT_W'(PROG_CYCLES - 1);
               pg_st_next = PG_TIMER;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         PG_TIMER: begin
            if (cnt_reg == '0) begin
               idx_next = '0;
               pg_st_next = PG_COMMIT;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         PG_COMMIT: begin
            // only loaded bytes reach the array, the rest keep their data
            ee_wr_next = mask_reg[idx_reg];
            ee_addr_next = {page_reg, idx_reg};
            ee_wdata_next = buf_reg[idx_reg];
            idx_next = idx_reg + 1'b1;
            if (idx_reg == dee_pkg::PAGE_IW'(dee_pkg::PAGE_BYTES - 1)) begin
               mask_next = '0;
               pg_st_next = PG_IDLE;
            end
         end
      endcase
   end

   // write buffer and programming sequencer registers
   always_ff @(posedge clk) begin
      if (srst) begin
         pg_st_reg <= PG_IDLE;
         cnt_reg <= '0;
         mask_reg <= '0;
         page_reg <= '0;
         idx_reg <= '0;
         last_reg <= 8'h00;
         ee_rd_reg <= 1'b0;
         ee_wr_reg <= 1'b0;
         ee_addr_reg <= 11'h000;
         ee_wdata_reg <= 8'h00;
      end else begin
         pg_st_reg <= pg_st_next;
         cnt_reg <= cnt_next;
         mask_reg <= mask_next;
         page_reg <= page_next;
         idx_reg <= idx_next;
         last_reg <= last_next;
         ee_rd_reg <= ee_rd_next;
         ee_wr_reg <= ee_wr_next;
         ee_addr_reg <= ee_addr_next;
         ee_wdata_reg <= ee_wdata_next;
      end
   end

   // buffer bytes carry no reset; the mask marks which ones are valid
   always_ff @(posedge clk) begin
      buf_reg <= buf_next;
   end

   // outputs straight from flip-flops
   assign sfr_rdata = sfr_rdata_reg;
   assign mv_rdata = mv_rdata_reg;
   assign mv_done = mv_done_reg;
   assign ext_req = ext_req_reg;
   assign ext_write = ext_write_reg;
   assign ext_addr = ext_addr_reg;
   assign ext_wdata = ext_wdata_reg;
   assign ee_rd = ee_rd_reg;
   assign ee_wr = ee_wr_reg;
   assign ee_addr = ee_addr_reg;
   assign ee_wdata = ee_wdata_reg;
endmodule : dee_ctrl
`default_nettype wire

/* dee_mem_model.sv */
// model of the eeprom cells and the off-chip data memory behind the controller
`timescale 1ns/100ps
`default_nettype none
module dee_mem_model (
   // clock
   input wire logic clk,
   // eeprom array side
   input wire logic ee_rd,
   input wire logic ee_wr,
   input wire logic [10:0] ee_addr,
   input wire logic [7:0] ee_wdata,
   output logic [7:0] ee_rdata,
   // off-chip side, ack after ext_wait idle cycles
   input wire logic ext_req,
   input wire logic ext_write,
   input wire logic [15:0] ext_addr,
   input wire logic [7:0] ext_wdata,
   output logic ext_ack,
   output logic [7:0] ext_rdata,
   input wire logic [3:0] ext_wait
);
   logic [7:0] ee_mem [2048]; // erased cells read ff
   logic [7:0] ext_mem [256]; // low address byte only, so high pages alias
   logic [3:0] wait_reg = 4'h0;
   initial begin
      ext_ack = 1'b0;
      ext_rdata = 8'h00;
      for (int i = 0; i < 2048; i++) begin
         ee_mem[i] = 8'hff;
      end
   end
   // cells change one byte at a time, only on a write pulse
   always @(posedge clk) begin
      if (ee_wr) begin
         ee_mem[ee_addr] <= ee_wdata;
      end
      ext_ack <= 1'b0;
      ext_rdata <= ~ext_rdata; // no stale data outside the ack cycle
      if (ext_req && !ext_ack) begin
         wait_reg <= wait_reg + 4'h1;
         if (wait_reg == ext_wait) begin
            wait_reg <= 4'h0;
            ext_ack <= 1'b1;
            ext_rdata <= ext_mem[ext_addr[7:0]];
            if (ext_write) begin
               ext_mem[ext_addr[7:0]] <= ext_wdata;
            end
         end
      end
   end
   // array read is combinational; garbage when not reading
   always_comb begin
      ee_rdata = ee_rd ? ee_mem[ee_addr] : ~ee_wdata;
   end
endmodule : dee_mem_model
`default_nettype wire

/* dee_ctrl_chk.sv */
// port checker for the data eeprom access controller
`timescale 1ns/100ps
`default_nettype none
module dee_chk (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   // move port
   input wire logic mv_req,
   input wire logic mv_write,
   input wire logic [7:0] mv_rdata,
   input wire logic mv_done,
   // memory sides
   input wire logic ext_req,
   input wire logic ext_write,
   input wire logic [15:0] ext_addr,
   input wire logic ext_ack,
   input wire logic [7:0] ext_rdata,
   input wire logic ee_rd,
   input wire logic ee_wr,
   input wire logic [7:0] ee_rdata
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic [1:0] ctl_reg; // shadow of write enable and select
   logic [1:0] ctl_next;
   logic we_arm_reg; // an enabled write move has been issued
   logic we_arm_next;
   // track the control bits from register writes
   always_comb begin
      ctl_next = ctl_reg;
      we_arm_next = we_arm_reg;
      if (sfr_wr && sfr_addr == 8'h96) ctl_next = sfr_wdata[4:3];
      // software may drop enable while the array is still programming
      if (mv_req && mv_write && ctl_reg[1]) begin
         we_arm_next = 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      ctl_reg <= srst ? 2'b00 : ctl_next;
      we_arm_reg <= srst ? 1'b0 : we_arm_next;
   end
   property p_eerd; ee_rd |=> mv_done && mv_rdata == $past(ee_rdata); endproperty
   a_eerd: assert property (p_eerd) else $error("array read not returned");
   property p_route; mv_req && !ctl_reg[0] |=> ext_req && ext_write == $past(mv_write); endproperty
   a_route: assert property (p_route) else $error("move not sent off-chip");
   property p_hold; ext_req && !ext_ack |=> ext_req && $stable(ext_addr); endproperty
   a_hold: assert property (p_hold) else $error("off-chip request dropped");
   property p_exdone; ext_req && ext_ack |=> !ext_req && mv_done; endproperty
   a_exdone: assert property (p_exdone) else $error("off-chip move not closed");
   property p_exrd; ext_req && ext_ack && !ext_write |=> mv_rdata == $past(ext_rdata); endproperty
   a_exrd: assert property (p_exrd) else $error("off-chip read data lost");
   property p_onerw; !(ee_rd && ee_wr); endproperty
   a_onerw: assert property (p_onerw) else $error("array read and write together");
   property p_we; ee_wr |-> we_arm_reg; endproperty
   a_we: assert property (p_we) else $error("array written without enable");
   property p_unmap;
      sfr_rd && !(sfr_addr inside {8'h82, 8'h83, 8'h84, 8'h85, 8'h96}) |=> sfr_rdata == 8'h00;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_hibits; sfr_rd && sfr_addr == 8'h96 |=> sfr_rdata[7:6] == 2'b00; endproperty
   a_hibits: assert property (p_hibits) else $error("control top bits set");
   c_eewr: cover property (ee_wr);
   c_eerd: cover property (ee_rd);
   c_ack: cover property (ext_req && ext_ack);
endmodule : dee_chk
bind dee_ctrl dee_chk chk_u (.clk, .srst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
   .mv_req, .mv_write, .mv_rdata, .mv_done, .ext_req, .ext_write, .ext_addr, .ext_ack,
   .ext_rdata, .ee_rd, .ee_wr, .ee_rdata);
`default_nettype wire

/* dee_ctrl_tb_top.sv */
// self-checking bench for the data eeprom access controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module dee_ctrl_tb_top;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic sfr_wr = 1'b0, sfr_rd = 1'b0, mv_req = 1'b0, mv_write = 1'b0, supply_ok_in = 1'b1;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, mv_wdata = 8'h00, d;
   logic [3:0] ext_wait = 4'h0; // off-chip answer delay
   logic [7:0] sfr_rdata, mv_rdata, ext_wdata, ext_rdata, ee_wdata, ee_rdata;
   logic [15:0] ext_addr;
   logic [10:0] ee_addr;
   logic mv_done, ext_req, ext_write, ext_ack, ee_rd, ee_wr;
   int failures = 0, n_tests = 0, cyc = 0, c;
   always #20 clk = ~clk;
   // short programming time keeps the run brief
   dee_ctrl #(.PROG_CYCLES(20)) dut_u (.clk, .srst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
      .sfr_rdata, .mv_req, .mv_write, .mv_wdata, .mv_rdata, .mv_done, .ext_req, .ext_write,
      .ext_addr, .ext_wdata, .ext_ack, .ext_rdata, .ee_rd, .ee_wr, .ee_addr, .ee_wdata,
      .ee_rdata, .supply_ok_in);
   dee_mem_model mem_u (.clk, .ee_rd, .ee_wr, .ee_addr, .ee_wdata, .ee_rdata, .ext_req,
      .ext_write, .ext_addr, .ext_wdata, .ext_ack, .ext_rdata, .ext_wait);
   task automatic sfr_w(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = v;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask : sfr_w
   task automatic sfr_r(input logic [7:0] a, output logic [7:0] v);
      @(negedge clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk);
      sfr_rd = 1'b0;
      @(negedge clk);
      v = sfr_rdata;
   endtask : sfr_r
   // one move, waits for its done pulse under a bound
   task automatic mv(input logic w, input logic [7:0] v, output logic [7:0] r);
      int k;
      @(negedge clk);
      mv_req = 1'b1;
      mv_write = w;
      mv_wdata = v;
      @(negedge clk);
      mv_req = 1'b0;
      for (k = 0; k < 40 && mv_done !== 1'b1; k++) begin
         @(negedge clk);
      end
      `CHK(mv_done, 1'b1)
      r = mv_rdata;
   endtask : mv
   // waits for ready to fall, then counts cycles until it rises
   task automatic wait_busy(output int n);
      logic [7:0] v;
      n = 0;
      v = 8'h02;
      for (int k = 0; k < 10 && v[1]; k++) begin
         sfr_r(8'h96, v);
      end
      while (n < 300 && v[1] !== 1'b1) begin
         sfr_r(8'h96, v);
         n += 3;
      end
   endtask : wait_busy
   task automatic t_regs();
      sfr_r(8'h96, d);
      `CHK(d, 8'h03)
      for (int i = 0; i < 4; i++) begin
         sfr_w(8'h82 + 8'(i), 8'ha5 ^ 8'(i));
      end
      for (int i = 0; i < 4; i++) begin
         sfr_r(8'h82 + 8'(i), d);
         `CHK(d, 8'ha5 ^ 8'(i))
      end
      sfr_w(8'h96, 8'hff);
      sfr_r(8'h96, d);
      `CHK(d, 8'h3f)
      sfr_w(8'h97, 8'h55);
      sfr_r(8'h97, d);
      `CHK(d, 8'h00)
   endtask : t_regs
   task automatic t_route();
      sfr_w(8'h96, 8'h00);
      sfr_w(8'h82, 8'h10);
      sfr_w(8'h83, 8'h00);
      sfr_w(8'h84, 8'h30);
      sfr_w(8'h85, 8'h08);
      mv(1'b1, 8'h11, d);
      `CHK(mem_u.ext_mem[8'h10], 8'h11)
      // select on, bank one chosen before use, it points above 2K
      sfr_w(8'h96, 8'h0c);
      ext_wait = 4'h3;
      mv(1'b1, 8'h22, d);
      `CHK(mem_u.ext_mem[8'h30], 8'h22)
      mv(1'b0, 8'h00, d);
      `CHK(d, 8'h22)
      `CHK(mem_u.ee_mem[11'h030], 8'hff)
      ext_wait = 4'h0;
   endtask : t_route
   task automatic t_byte();
      sfr_w(8'h82, 8'h05);
      sfr_w(8'h96, 8'h08); // select on, write enable off
      mv(1'b1, 8'h5a, d);
      repeat (40) @(negedge clk);
      `CHK(mem_u.ee_mem[11'h005], 8'hff)
      sfr_w(8'h96, 8'h18);
      mv(1'b1, 8'h5a, d);
      sfr_r(8'h96, d);
      `CHK(d[1], 1'b1)
      repeat (6) @(negedge clk);
      mv(1'b0, 8'h00, d);
      `CHK(d, 8'hda)
      wait_busy(c);
      `CHK(c < 300, 1'b1)
      sfr_w(8'h96, 8'h08);
      mv(1'b0, 8'h00, d);
      `CHK(d, 8'h5a)
      `CHK(mem_u.ee_mem[11'h004], 8'hff)
      `CHK(mem_u.ee_mem[11'h006], 8'hff)
      // last eeprom byte stays on-chip, the next address goes off-chip
      sfr_w(8'h82, 8'hff);
      sfr_w(8'h83, 8'h07);
      mv(1'b0, 8'h00, d);
      `CHK(d, 8'hff)
      sfr_w(8'h82, 8'h00);
      sfr_w(8'h83, 8'h08);
      mv(1'b1, 8'h3c, d);
      `CHK(mem_u.ext_mem[8'h00], 8'h3c)
      `CHK(mem_u.ee_mem[11'h000], 8'hff)
      sfr_w(8'h83, 8'h00);
   endtask : t_byte
   task automatic t_page();
      sfr_w(8'h96, 8'h38); // load only
      sfr_w(8'h82, 8'h40);
      mv(1'b1, 8'h40, d);
      sfr_w(8'h82, 8'h41);
      mv(1'b1, 8'h41, d);
      repeat (30) @(negedge clk);
      `CHK(mem_u.ee_mem[11'h040], 8'hff)
      sfr_w(8'h96, 8'h18);
      sfr_w(8'h82, 8'h5f); // last byte of the same page
      mv(1'b1, 8'h5f, d);
      wait_busy(c);
      `CHK(c >= 20, 1'b1)
      `CHK(c < 66, 1'b1)
      sfr_w(8'h96, 8'h08);
      `CHK(mem_u.ee_mem[11'h040], 8'h40)
      `CHK(mem_u.ee_mem[11'h041], 8'h41)
      `CHK(mem_u.ee_mem[11'h05f], 8'h5f)
      `CHK(mem_u.ee_mem[11'h042], 8'hff)
   endtask : t_page
   task automatic t_inh();
      @(negedge clk);
      supply_ok_in = 1'b0;
      repeat (8) @(negedge clk);
      sfr_r(8'h96, d);
      `CHK(d[0], 1'b0)
      sfr_w(8'h96, 8'h18);
      sfr_w(8'h82, 8'h07);
      mv(1'b1, 8'h77, d);
      repeat (40) @(negedge clk);
      `CHK(mem_u.ee_mem[11'h007], 8'hff)
      supply_ok_in = 1'b1;
      sfr_w(8'h96, 8'h00);
   endtask : t_inh
   task automatic tally_and_finish();
      $display("failures=%0d n_tests=%0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish
   // hang guard, well above the expected run length
   always @(negedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (6) @(negedge clk);
      srst = 1'b0;
      repeat (6) @(negedge clk); // supply sync settles
      t_regs();
      t_route();
      t_byte();
      t_page();
      t_inh();
      tally_and_finish();
   end
endmodule : dee_ctrl_tb_top
`default_nettype wire
